// [verilog/acp_regs.svh]
`ifndef ACP_REGS_SVH
`define ACP_REGS_SVH

// framing and reply characters
`define ACP_CH_LF      8'h0a
`define ACP_CH_CR      8'h0d
`define ACP_CH_BLANK   8'h20
`define ACP_CH_QUOTE   8'h22
`define ACP_CH_DASH    8'h2d
`define ACP_CH_GT      8'h3e
`define ACP_CH_ERR     8'h45
`define ACP_CH_WARN    8'h57
`define ACP_CH_ZERO    8'h30

// message numbers, last digit only; leading digits are always zero
`define ACP_ERR_LONG   8'h31
`define ACP_ERR_QUOTE  8'h32
`define ACP_ERR_CR     8'h33
`define ACP_ERR_NAME   8'h34
`define ACP_WRN_TRUNC  8'h31

// storage sizes
`define ACP_LINE_DEPTH 6'h20
`define ACP_SLOT_DEPTH 6'h10

// timing
`define ACP_CLK_PERIOD_NS 8
`define ACP_STEP_TIME_S   1
`define ACP_STEP_CYCLES   (`ACP_STEP_TIME_S * 1000000000 / `ACP_CLK_PERIOD_NS)
`define ACP_HOLD_MIN_S    5'h0a
`define ACP_HOLD_MAX_S    5'h0f

// factory output codes at 0 % and 100 % of full_scale_span
`define ACP_SCALE_ZERO 16'h0283
`define ACP_SCALE_FULL 16'hfd77

`endif

// [verilog/acp_pkg.sv]
package acp_pkg;

  typedef enum logic [3:0] {
    ST_RECV = 4'b0000,
    ST_NAME = 4'b0001,
    ST_SEP  = 4'b0010,
    ST_PARM = 4'b0011,
    ST_CODE = 4'b0100,
    ST_CR   = 4'b0101,
    ST_LF   = 4'b0110,
    ST_DASH = 4'b0111,
    ST_GT   = 4'b1000
  } acp_state_type;

  typedef enum logic [1:0] {
    LED_OFF = 2'b00,
    LED_RED = 2'b01,
    LED_YEL = 2'b10,
    LED_GRN = 2'b11
  } acp_led_type;

endpackage : acp_pkg

// [verilog/acp_byte_if.sv]
`timescale 1ns/1ps
// one byte stream with valid/ready handshake
interface acp_byte_if;
  logic       valid;
  logic       ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : acp_byte_if

// [verilog/acp_out_buf.sv]
`timescale 1ns/1ps
// two-entry buffer so a receiver stall never drops a reply byte
module acp_out_buf (
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  acp_byte_if.snk         up_if,
  output logic            dn_valid_out,
  output logic [7:0]      dn_data_out,
  input  wire logic       dn_ready_in
);
  logic [7:0] mem [0:1];
  logic       wr_ptr;
  logic       rd_ptr;
  logic [1:0] count;

  // handshake decode
  wire push = up_if.valid && up_if.ready;
  wire pop  = dn_valid_out && dn_ready_in;
  assign up_if.ready  = (count != 2'h2);
  assign dn_valid_out = (count != 2'h0);
  assign dn_data_out  = mem[rd_ptr];

  // pointers and occupancy
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      if (push) wr_ptr <= !wr_ptr;
      if (pop) rd_ptr <= !rd_ptr;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

  // storage has no reset; contents are only read while count says valid
  always_ff @(posedge mclk_in) begin
    if (push) mem[wr_ptr] <= up_if.data;
  end
endmodule : acp_out_buf

// [verilog/acp_cmd_parser.sv]
`timescale 1ns/1ps
`include "acp_regs.svh"
module acp_cmd_parser #(
  parameter int STEP_CYCLES = `ACP_STEP_CYCLES
) (
  input  wire logic       mclk_in,
  input  wire logic       rst_n_in,
  input  wire logic       rx_valid_in,
  input  wire logic [7:0] rx_data_in,
  output logic            rx_ready_out,
  output logic            tx_valid_out,
  output logic [7:0]      tx_data_out,
  input  wire logic       tx_ready_in,
  input  wire logic       key_in,
  output logic [1:0]      led_state_out,
  output logic            restore_out,
  output logic [15:0]     scale_zero_out,
  output logic [15:0]     scale_full_out
);
  acp_byte_if            out_if ();
  acp_pkg::acp_state_type state;
  logic [7:0]  line_buf [0:31];
  logic [5:0]  wr_cnt;
  logic [5:0]  name_len;
  logic        name_done;
  logic        in_quote;
  logic        cr_seen;
  logic        cr_bad;
  logic        too_long;
  logic [4:0]  slot_len [0:3];
  logic [1:0]  cur_slot;
  logic [5:0]  idx;
  logic        code_warn;
  logic [7:0]  code_char;
  logic [26:0] tick_cnt;
  logic [1:0]  start_step;
  logic        key_armed;
  logic [26:0] hold_cyc;
  logic [4:0]  hold_sec;

  // receive-side decode
  wire rx_take   = rx_valid_in && rx_ready_out;
  wire is_lf     = (rx_data_in == `ACP_CH_LF);
  wire is_cr     = (rx_data_in == `ACP_CH_CR);
  wire is_quote  = (rx_data_in == `ACP_CH_QUOTE);
  wire sep       = (rx_data_in == `ACP_CH_BLANK) && !in_quote;
  wire [5:0] par_len = wr_cnt - name_len;
  wire has_param = name_done && (par_len != 6'h00);
  wire [1:0] hash = line_buf[0][1:0] ^ name_len[1:0];
  wire finish    = rx_take && is_lf;
  wire skip_byte = sep && (!name_done || par_len == 6'h00);
  wire keep_byte = rx_take && !is_lf && !is_cr && !skip_byte;
  wire over_slot = (par_len > `ACP_SLOT_DEPTH);
  wire [4:0] new_len = over_slot ? 5'(`ACP_SLOT_DEPTH) : par_len[4:0];

  // error choice at end of line; overflow beats quote beats CR
  wire [7:0] err_char = too_long               ? `ACP_ERR_LONG  :
                        in_quote               ? `ACP_ERR_QUOTE :
                        cr_bad                 ? `ACP_ERR_CR    :
                        (name_len == 6'h00)    ? `ACP_ERR_NAME  : 8'h00;
  wire       is_err   = (err_char != 8'h00);
  wire       store_now = finish && !is_err && has_param;

  // reply byte selection
  wire [7:0] slot_byte [0:15];
  wire       out_go  = out_if.valid && out_if.ready;
  wire [4:0] cur_len = slot_len[cur_slot];
  wire [7:0] code_byte = (idx == 6'h00) ? (code_warn ? `ACP_CH_WARN : `ACP_CH_ERR) :
                         (idx == 6'h03) ? code_char : `ACP_CH_ZERO;
  assign rx_ready_out = (state == acp_pkg::ST_RECV);
  assign out_if.valid = (state != acp_pkg::ST_RECV);
  assign out_if.data  = (state == acp_pkg::ST_NAME) ? line_buf[idx[4:0]] :
                        (state == acp_pkg::ST_SEP)  ? `ACP_CH_BLANK :
                        (state == acp_pkg::ST_PARM) ? slot_byte[idx[3:0]] :
                        (state == acp_pkg::ST_CODE) ? code_byte :
                        (state == acp_pkg::ST_CR)   ? `ACP_CH_CR :
                        (state == acp_pkg::ST_LF)   ? `ACP_CH_LF :
                        (state == acp_pkg::ST_DASH) ? `ACP_CH_DASH : `ACP_CH_GT;

  always_ff @(posedge mclk_in) begin
    if (keep_byte && wr_cnt != `ACP_LINE_DEPTH) line_buf[wr_cnt[4:0]] <= rx_data_in;
  end

  // parser flags; name_len lives until the reply's closing '>' has been handed to the buffer
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_cnt    <= 6'h00;
      name_len  <= 6'h00;
      name_done <= 1'b0;
      in_quote  <= 1'b0;
      cr_seen   <= 1'b0;
      cr_bad    <= 1'b0;
      too_long  <= 1'b0;
    end else if (finish) begin
      wr_cnt    <= 6'h00;
      name_done <= 1'b0;
      in_quote  <= 1'b0;
      cr_seen   <= 1'b0;
      cr_bad    <= 1'b0;
      too_long  <= 1'b0;
    end else if (rx_take) begin
      // cr only legal right before lf
      cr_seen <= is_cr;
      if (cr_seen) cr_bad <= 1'b1;
      // quotes hold blanks inside a parameter
      if (is_quote && !is_cr) in_quote <= !in_quote;
      // first outside blank ends the name
      if (sep && !name_done && name_len != 6'h00) name_done <= 1'b1;
      if (keep_byte && wr_cnt == `ACP_LINE_DEPTH) too_long <= 1'b1;
      if (keep_byte && wr_cnt != `ACP_LINE_DEPTH) wr_cnt <= wr_cnt + 6'h01;
      if (keep_byte && wr_cnt != `ACP_LINE_DEPTH && !name_done) name_len <= name_len + 6'h01;
    end else if (state == acp_pkg::ST_GT && out_go) begin
      name_len <= 6'h00;
    end
  end

  // setting slots, one column of flops per byte position
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_col
      logic [7:0] col [0:3];
      wire  [4:0] src = name_len[4:0] + 5'(g);
      always_ff @(posedge mclk_in) begin
        if (store_now) col[hash] <= line_buf[src];
      end
      assign slot_byte[g] = col[cur_slot];
    end
  endgenerate

  // slot lengths; a restore forgets every stored value
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < 4; i++) slot_len[i] <= 5'h00;
    end else if (restore_out) begin
      for (int i = 0; i < 4; i++) slot_len[i] <= 5'h00;
    end else if (store_now) begin
      slot_len[hash] <= new_len;
    end
  end

  // reply sequencer
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state     <= acp_pkg::ST_RECV;
      idx       <= 6'h00;
      cur_slot  <= 2'h0;
      code_warn <= 1'b0;
      code_char <= 8'h00;
    end else begin
      case (state)
        acp_pkg::ST_RECV: begin
          idx <= 6'h00;
          if (finish) begin
            cur_slot <= hash;
            code_warn <= !is_err;
            code_char <= is_err ? err_char : `ACP_WRN_TRUNC;
            if (is_err) state <= acp_pkg::ST_CODE;
            // warning after the value is stored
            else if (has_param && over_slot) state <= acp_pkg::ST_CODE;
            else if (has_param) state <= acp_pkg::ST_CR;
            else state <= acp_pkg::ST_NAME;
          end
        end
        acp_pkg::ST_NAME: if (out_go) begin
          // reply starts with the command name
          idx <= idx + 6'h01;
          if (idx == name_len - 6'h01) begin
            idx <= 6'h00;
            state <= (cur_len != 5'h00) ? acp_pkg::ST_SEP : acp_pkg::ST_CR;
          end
        end
        acp_pkg::ST_SEP: if (out_go) state <= acp_pkg::ST_PARM;
        acp_pkg::ST_PARM: if (out_go) begin
          idx <= idx + 6'h01;
          if (idx == {1'b0, cur_len} - 6'h01) state <= acp_pkg::ST_CR;
        end
        acp_pkg::ST_CODE: if (out_go) begin
          idx <= idx + 6'h01;
          if (idx == 6'h03) state <= acp_pkg::ST_CR;
        end
        acp_pkg::ST_CR:   if (out_go) state <= acp_pkg::ST_LF;
        acp_pkg::ST_LF:   if (out_go) state <= acp_pkg::ST_DASH;
        acp_pkg::ST_DASH: if (out_go) state <= acp_pkg::ST_GT;
        acp_pkg::ST_GT:   if (out_go) state <= acp_pkg::ST_RECV;
        default: state <= acp_pkg::ST_RECV;
      endcase
    end
  end

  acp_out_buf u_buf (
    .mclk_in      (mclk_in),
    .rst_n_in     (rst_n_in),
    .up_if        (out_if),
    .dn_valid_out (tx_valid_out),
    .dn_data_out  (tx_data_out),
    .dn_ready_in  (tx_ready_in)
  );

  // power-up timing, one step per second
  wire sec_tick   = (tick_cnt == 27'(STEP_CYCLES - 1));
  wire in_start   = (start_step != 2'h3);
  wire hold_win   = (hold_sec >= `ACP_HOLD_MIN_S) && (hold_sec < `ACP_HOLD_MAX_S);
  wire hold_tick  = (hold_cyc == 27'(STEP_CYCLES - 1));
  wire flash_on   = key_armed && key_in && hold_win;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tick_cnt   <= 27'h000_0000;
      start_step <= 2'h0;
    end else if (in_start) begin
      tick_cnt <= sec_tick ? 27'h000_0000 : tick_cnt + 27'h000_0001;
      if (sec_tick) start_step <= start_step + 2'h1;
    end
  end

  // key held from the start sequence, counted from its own press
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      key_armed   <= 1'b0;
      hold_cyc    <= 27'h000_0000;
      hold_sec    <= 5'h00;
      restore_out <= 1'b0;
    end else begin
      restore_out <= key_armed && !key_in && hold_win;
      if (!key_armed) begin
        key_armed <= in_start && key_in;
        hold_cyc  <= 27'h000_0000;
        hold_sec  <= 5'h00;
      end else if (!key_in) begin
        key_armed <= 1'b0;
      end else begin
        hold_cyc <= hold_tick ? 27'h000_0000 : hold_cyc + 27'h000_0001;
        // saturate past the window so a long hold never restores
        if (hold_tick && hold_sec != 5'h1f) hold_sec <= hold_sec + 5'h01;
      end
    end
  end

  // indicator: start colours, then yellow flash while release is valid
  assign led_state_out = (start_step == 2'h0) ? acp_pkg::LED_RED :
                         (start_step == 2'h1) ? acp_pkg::LED_YEL :
                         (start_step == 2'h2) ? acp_pkg::LED_GRN :
                         flash_on ? (hold_cyc[26] ? acp_pkg::LED_OFF : acp_pkg::LED_YEL) :
                         acp_pkg::LED_GRN;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scale_zero_out <= `ACP_SCALE_ZERO;
      scale_full_out <= `ACP_SCALE_FULL;
    end else if (restore_out) begin
      scale_zero_out <= `ACP_SCALE_ZERO;
      scale_full_out <= `ACP_SCALE_FULL;
    end
  end
endmodule : acp_cmd_parser

// [sim/acp_cmd_parser_monitor.sv]
`timescale 1ns/1ps
// watches the parser top ports only
module acp_mon_chk #(
  parameter int STEP_CYCLES = 20
) (
  input wire logic        mclk_in,
  input wire logic        rst_n_in,
  input wire logic        rx_valid_in,
  input wire logic [7:0]  rx_data_in,
  input wire logic        rx_ready_out,
  input wire logic        tx_valid_out,
  input wire logic [7:0]  tx_data_out,
  input wire logic        tx_ready_in,
  input wire logic        key_in,
  input wire logic [1:0]  led_state_out,
  input wire logic        restore_out,
  input wire logic [15:0] scale_zero_out,
  input wire logic [15:0] scale_full_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  // a line feed taken from the host closes the line
  wire lf_take = rx_valid_in && rx_ready_out && rx_data_in == 8'h0a;

  a_line_end_stall: assert property (lf_take |=> !rx_ready_out)
    else $error("ready stays high after line end");
  a_reply_starts: assert property (lf_take |-> ##2 tx_valid_out)
    else $error("reply not started two cycles after line end");
  a_prompt_returns: assert property ($fell(rx_ready_out) |-> ##[1:300] rx_ready_out)
    else $error("parser never returns to receive");
  a_reply_byte_held: assert property (tx_valid_out && !tx_ready_in |=>
    tx_valid_out && $stable(tx_data_out))
    else $error("reply byte lost during stall");
  a_restore_single: assert property (restore_out |=> !restore_out)
    else $error("restore longer than one cycle");
  a_restore_on_release: assert property ($rose(restore_out) |->
    !key_in && ($past(key_in, 2) || $past(key_in, 3)))
    else $error("restore without key release");
  a_led_green_order: assert property ($changed(led_state_out) &&
    led_state_out == acp_pkg::LED_GRN |-> $past(led_state_out) == acp_pkg::LED_YEL)
    else $error("green reached not from yellow");
  a_scale_codes: assert property (scale_zero_out == 16'h0283 &&
    scale_full_out == 16'hfd77)
    else $error("output scale codes wrong");

  // main scenarios reached
  c_line: cover property (lf_take);
  c_restore: cover property (restore_out);
  c_stall: cover property (tx_valid_out && !tx_ready_in);
endmodule : acp_mon_chk

bind acp_cmd_parser acp_mon_chk #(.STEP_CYCLES(STEP_CYCLES)) acp_mon_chk_i (
  .mclk_in(mclk_in), .rst_n_in(rst_n_in), .rx_valid_in(rx_valid_in),
  .rx_data_in(rx_data_in), .rx_ready_out(rx_ready_out), .tx_valid_out(tx_valid_out),
  .tx_data_out(tx_data_out), .tx_ready_in(tx_ready_in), .key_in(key_in),
  .led_state_out(led_state_out), .restore_out(restore_out),
  .scale_zero_out(scale_zero_out), .scale_full_out(scale_full_out));

// [sim/acp_host_model.sv]
`timescale 1ns/1ps
// host on the serial side: sends whole lines, collects replies
module acp_host_model (
  input  wire logic       mclk_in,
  input  wire logic       rx_ready_in,
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_data_in,
  output logic            rx_valid_out,
  output logic [7:0]      rx_data_out,
  output logic            tx_ready_out
);
  logic [7:0] txq[$];
  logic [7:0] got[$];
  logic       stall = 1'b0;
  logic       ph = 1'b0;
  initial begin
    rx_valid_out = 1'b0;
    rx_data_out = 8'h00;
    tx_ready_out = 1'b1;
  end
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) txq.push_back(s[i]);
  endtask : send
  // both handshakes complete on the rising edge
  always @(posedge mclk_in) begin
    if (rx_valid_out && rx_ready_in) void'(txq.pop_front());
    if (tx_valid_in && tx_ready_out) got.push_back(tx_data_in);
  end
  always @(negedge mclk_in) begin
    ph <= ~ph;
    tx_ready_out <= !stall || ph; // stall every other cycle
    rx_valid_out <= txq.size() != 0;
    // idle data keeps moving so a stale byte is never mistaken for one
    rx_data_out <= txq.size() != 0 ? txq[0] : ~rx_data_out;
  end
endmodule : acp_host_model

// [sim/testbench.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  n_tests++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("[FAIL] %s exp %0h got %0h", nm, e, g); \
  end \
end
module testbench;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        key = 1'b0;
  logic        rx_valid, rx_ready, tx_valid, tx_ready, restore;
  logic [7:0]  rx_data, tx_data;
  logic [1:0]  led;
  logic [15:0] sz, sf;
  int          n_errors = 0;
  int          n_tests = 0;
  int          n_rst = 0;
  int          cyc = 0;
  always #4 mclk = ~mclk;
  acp_cmd_parser #(.STEP_CYCLES(20)) acp_cmd_parser_i (.mclk_in(mclk), .rst_n_in(rst_n),
    .rx_valid_in(rx_valid), .rx_data_in(rx_data), .rx_ready_out(rx_ready),
    .tx_valid_out(tx_valid), .tx_data_out(tx_data), .tx_ready_in(tx_ready),
    .key_in(key), .led_state_out(led), .restore_out(restore),
    .scale_zero_out(sz), .scale_full_out(sf));
  acp_host_model acp_host_model_i (.mclk_in(mclk), .rx_ready_in(rx_ready),
    .tx_valid_in(tx_valid), .tx_data_in(tx_data), .rx_valid_out(rx_valid),
    .rx_data_out(rx_data), .tx_ready_out(tx_ready));
  // restore pulses counted; a hang is cut short
  always @(posedge mclk) begin
    cyc++;
    if (restore === 1'b1) n_rst++;
    if (cyc == 20000) begin
      n_errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (n_errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test
  task automatic do_reset();
    @(negedge mclk);
    rst_n = 1'b0;
    key = 1'b0;
    repeat (8) @(negedge mclk);
    rst_n = 1'b1;
  endtask : do_reset
  // one line out, whole reply back, compared byte by byte
  task automatic run(input string l, input string e);
    int k;
    k = 0;
    acp_host_model_i.got.delete();
    acp_host_model_i.send(l);
    while (acp_host_model_i.got.size() < e.len() && k < 400) begin
      @(negedge mclk);
      k++;
    end
    repeat (4) @(negedge mclk);
    `CHK("reply length", e.len(), acp_host_model_i.got.size())
    for (int i = 0; i < e.len() && i < acp_host_model_i.got.size(); i++)
      `CHK("reply byte", e[i], acp_host_model_i.got[i])
  endtask : run
  task automatic t_leds();
    do_reset();
    `CHK("scale zero", 16'h0283, sz)
    `CHK("scale full", 16'hfd77, sf)
    `CHK("idle ready", 1'b1, rx_ready)
    repeat (10) @(negedge mclk);
    `CHK("led first", acp_pkg::LED_RED, led)
    repeat (20) @(negedge mclk);
    `CHK("led second", acp_pkg::LED_YEL, led)
    repeat (20) @(negedge mclk);
    `CHK("led third", acp_pkg::LED_GRN, led)
    repeat (20) @(negedge mclk);
    `CHK("led after", acp_pkg::LED_GRN, led)
  endtask : t_leds
  // empty slot: query echoes the bare name
  task automatic t_query();
    run("AB\n", "AB\015\n->");
  endtask : t_query
  // quoted blank kept, CR LF ending, receiver stalling
  task automatic t_set();
    acp_host_model_i.stall = 1'b1;
    run("AB \"x y\"\015\n", "\015\n->");
    run("AB\n", "AB \"x y\"\015\n->");
    acp_host_model_i.stall = 1'b0;
  endtask : t_set
  // every fault leaves the stored value alone
  task automatic t_errors();
    run("AB \"q\n", "E002\015\n->");
    run("A\015B\n", "E003\015\n->");
    run("\n", "E004\015\n->");
    run("AB 0123456789012345678901234567890123456\n", "E001\015\n->");
    run("AB\n", "AB \"x y\"\015\n->");
  endtask : t_errors
  // over-long value is cut but still stored
  task automatic t_warn();
    run("CD 0123456789abcdefg\n", "W001\015\n->");
    run("CD\n", "CD 0123456789abcdef\015\n->");
  endtask : t_warn
  task automatic t_key(input int pre, input int hold, input int exp);
    do_reset();
    n_rst = 0;
    repeat (pre) @(negedge mclk);
    key = 1'b1;
    repeat (hold) @(negedge mclk);
    // light must show yellow exactly while a release would restore
    `CHK("led at release", exp ? acp_pkg::LED_YEL : acp_pkg::LED_GRN, led)
    key = 1'b0;
    repeat (6) @(negedge mclk);
    `CHK("restores", exp, n_rst)
    `CHK("restore idle", 1'b0, restore)
  endtask : t_key
  initial begin
    t_leds();
    t_query();
    t_set();
    t_errors();
    t_warn();
    t_key(5, 205, 1);
    t_key(5, 295, 1);
    t_key(5, 190, 0);
    t_key(5, 310, 0);
    t_key(70, 205, 0);
    stop_test();
  end
endmodule : testbench
